// file: rtl/sacs_map.vh
/*
 Register map, field positions, reset values and timing counts of the
 converter sequencer. Assumes a 100 MHz system clock and byte addressing.
*/
`ifndef SACS_MAP_VH
`define SACS_MAP_VH

// Register byte offsets
`define SACS_OFS_CTRL 6'h00
`define SACS_OFS_CFG 6'h04
`define SACS_OFS_RES_HI 6'h08
`define SACS_OFS_RES_LO 6'h0C
`define SACS_OFS_IRQ_STAT 6'h10
`define SACS_OFS_IRQ_MASK 6'h14

// Control register fields
`define SACS_CTRL_EN 7
`define SACS_CTRL_TM 6
`define SACS_CTRL_DONE 5
`define SACS_CTRL_ACT 4
`define SACS_CTRL_SRC_HI 3
`define SACS_CTRL_SRC_LO 2
`define SACS_CTRL_LJ 0

// Configuration register fields
`define SACS_CFG_DIV_HI 7
`define SACS_CFG_DIV_LO 3
`define SACS_CFG_GAIN_HI 2
`define SACS_CFG_GAIN_LO 0

// Reset values
`define SACS_CTRL_RST 8'h00
`define SACS_CFG_RST 8'hF8

// Start source codes
`define SACS_SRC_SW 2'b00
`define SACS_SRC_T3 2'b01
`define SACS_SRC_EXT 2'b10
`define SACS_SRC_T2 2'b11

// Timing
`define SACS_CLK_PERIOD_NS 10
`define SACS_MIN_SAMPLE_PERIOD_NS 10000
`define SACS_MIN_SAMPLE_CYCLES ((`SACS_MIN_SAMPLE_PERIOD_NS + `SACS_CLK_PERIOD_NS - 1) / `SACS_CLK_PERIOD_NS)
`define SACS_TRACK_SAR_CLOCKS 2'd3
`define SACS_RES_BITS 10

`endif

// file: rtl/sacs_sequencer.v
/*
 SAR converter sequencer: start source selection, tracking control, bitwise
 successive approximation, result justification, done flag and interrupt,
 with an Avalon-MM slave register file.
 Assumes: timer overflow pulses and standby come from logic on sys_clk; the
 external trigger and comparator come from outside and are synchronised here;
 the comparator settles within one SAR period less two system clocks.
*/
// Decided for this implementation: register access over Avalon-MM and the address map.
// Functional notes
// - Two-bit source field selects one of four start-of-conversion sources.
// - With software source, writing one to active flag starts a conversion.
// - Timer 3 overflow starts a conversion when that source is selected.
// - Rising edge of external trigger starts conversion when selected.
// - Timer 2 overflow starts a conversion when that source is selected.
// - Active flag is one during conversion, zero once it finishes.
// - Active flag falling sets done flag and raises interrupt if enabled.
// - Result in high/low registers, left or right justified by select bit.
// - Tracking mode zero: track continuously whenever not converting.
// - Tracking mode one: track three SAR clocks after start, then convert.
// - Low-power with external source: track while trigger low, convert on rise.
// - Tracking stops while the chip is in standby or sleep.
// - SAR clock is system clock divided by five-bit divider field plus one.
// - Conversion rate limited to at most 100 thousand samples per second.
`include "sacs_map.vh"
`default_nettype none

module sacs_sequencer (
	// Clock and reset
	input wire sys_clk,
	input wire sys_rst,
	// Avalon-MM slave
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	// Start sources and power state
	input wire timer2_overflow,
	input wire timer3_overflow,
	input wire external_convert_trigger,
	input wire chip_standby,
	// Analog front end
	input wire sar_compare_in,
	output reg sar_track_q,
	output reg [9:0] sar_dac_code_q,
	output reg [2:0] pga_gain_select_q,
	// Interrupt
	output reg irq_q
);

	// One-hot sequencer states
	localparam ST_IDLE = 3'b001;
	localparam ST_TRACK = 3'b010;
	localparam ST_CONV = 3'b100;
	// Reset images and start spacing, cut to register widths on purpose
	localparam [7:0] CTRL_RST = `SACS_CTRL_RST;
	localparam [7:0] CFG_RST = `SACS_CFG_RST;
	localparam integer RATE_CYCLES_I = `SACS_MIN_SAMPLE_CYCLES;
	localparam [9:0] RATE_CYCLES = RATE_CYCLES_I[9:0];

	// Justify a result into the high/low byte pair
	function [15:0] sacs_justify;
		input [9:0] res;
		input lj;
		begin
			if (lj) begin
				sacs_justify = {res, 6'b00_0000};
			end else begin
				sacs_justify = {6'b00_0000, res};
			end
		end
	endfunction

	// Register fields, sequencer state and synchroniser stages
	reg en_q, tm_q, done_q, lj_q;
	reg [1:0] src_q;
	reg [4:0] div_q;
	reg [9:0] result_q;
	reg stat_q, mask_q;
	reg [2:0] state_q;
	reg active_q;
	reg [4:0] div_cnt_q;
	reg [1:0] trk_cnt_q;
	reg [3:0] bit_idx_q;
	reg [9:0] rate_cnt_q;
	reg trig_s1_q, trig_s2_q, trig_s3_q;
	reg cmp_s1_q, cmp_s2_q;

	// Bus decode; a write counts only at its acknowledge edge, so a held request acts once
	wire wr_ack = avs_write & ~avs_waitrequest & avs_byteenable[0];
	wire wr_ctrl = wr_ack & (avs_address == `SACS_OFS_CTRL);
	wire wr_cfg = wr_ack & (avs_address == `SACS_OFS_CFG);
	wire wr_stat = wr_ack & (avs_address == `SACS_OFS_IRQ_STAT);
	wire wr_mask = wr_ack & (avs_address == `SACS_OFS_IRQ_MASK);
	wire trig_rise = trig_s2_q & ~trig_s3_q;
	wire sar_tick = (div_cnt_q == 5'd0);
	wire [15:0] res_pair = sacs_justify(result_q, lj_q);
	wire [7:0] ctrl_rd = {en_q, tm_q, done_q, active_q, src_q, 1'b0, lj_q};

	// Start event selected by the source field
	reg start_evt;
	always @* begin
		case (src_q)
		`SACS_SRC_SW: start_evt = wr_ctrl & avs_writedata[`SACS_CTRL_ACT];
		`SACS_SRC_T3: start_evt = timer3_overflow;
		`SACS_SRC_EXT: start_evt = trig_rise;
		default: start_evt = timer2_overflow;
		endcase
	end

	// Busy conversions, disabled converter and the rate limit all drop starts
	wire start_take = start_evt & en_q & (state_q == ST_IDLE) & (rate_cnt_q == 10'd0);
	wire finish = (state_q == ST_CONV) & sar_tick & (bit_idx_q == 4'd0);

	// Synchronisers: first stage is read only by the second
	// The comparator is treated as asynchronous, so its decision arrives two cycles late
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
			trig_s3_q <= 1'b0;
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			trig_s1_q <= external_convert_trigger;
			trig_s2_q <= trig_s1_q;
			trig_s3_q <= trig_s2_q; // Edge history
			cmp_s1_q <= sar_compare_in;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	// Bus handshake: one wait state, then a single ack cycle
	// Read data is captured in the wait cycle and stands until the next read
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
			if (avs_read & avs_waitrequest) begin
				case (avs_address)
				`SACS_OFS_CTRL: avs_readdata <= {24'h00_0000, ctrl_rd};
				`SACS_OFS_CFG: avs_readdata <= {24'h00_0000, div_q, pga_gain_select_q};
				`SACS_OFS_RES_HI: avs_readdata <= {24'h00_0000, res_pair[15:8]};
				`SACS_OFS_RES_LO: avs_readdata <= {24'h00_0000, res_pair[7:0]};
				`SACS_OFS_IRQ_STAT: avs_readdata <= {31'h0000_0000, stat_q};
				`SACS_OFS_IRQ_MASK: avs_readdata <= {31'h0000_0000, mask_q};
				default: avs_readdata <= 32'h0000_0000; // Unmapped reads as zero
				endcase
			end
		end
	end

	// Control and configuration fields
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			en_q <= CTRL_RST[`SACS_CTRL_EN];
			tm_q <= CTRL_RST[`SACS_CTRL_TM];
			src_q <= CTRL_RST[`SACS_CTRL_SRC_HI:`SACS_CTRL_SRC_LO];
			lj_q <= CTRL_RST[`SACS_CTRL_LJ];
			div_q <= CFG_RST[`SACS_CFG_DIV_HI:`SACS_CFG_DIV_LO];
			pga_gain_select_q <= CFG_RST[`SACS_CFG_GAIN_HI:`SACS_CFG_GAIN_LO];
			mask_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				en_q <= avs_writedata[`SACS_CTRL_EN];
				tm_q <= avs_writedata[`SACS_CTRL_TM];
				src_q <= avs_writedata[`SACS_CTRL_SRC_HI:`SACS_CTRL_SRC_LO];
				lj_q <= avs_writedata[`SACS_CTRL_LJ];
			end
			if (wr_cfg) begin
				div_q <= avs_writedata[`SACS_CFG_DIV_HI:`SACS_CFG_DIV_LO];
				pga_gain_select_q <= avs_writedata[`SACS_CFG_GAIN_HI:`SACS_CFG_GAIN_LO];
			end
			if (wr_mask) begin
				mask_q <= avs_writedata[0];
			end
		end
	end

	// Done flag and sticky status; a completion beats a same-cycle clear
	// Writing one to the done bit leaves it alone, so a read-modify-write cannot lose it
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			done_q <= 1'b0;
			stat_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			if (finish) begin
				done_q <= 1'b1;
			end else if (wr_ctrl & ~avs_writedata[`SACS_CTRL_DONE]) begin
				done_q <= 1'b0;
			end
			if (finish) begin
				stat_q <= 1'b1;
			end else if (wr_stat & avs_writedata[0]) begin
				stat_q <= 1'b0;
			end
			irq_q <= (stat_q | finish) & mask_q & ~(wr_mask & ~avs_writedata[0]);
		end
	end

	// SAR clock divider, realigned on each accepted start
	// Realigning puts the first tick exactly one SAR period after the start
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			div_cnt_q <= 5'd0;
		end else if (start_take | sar_tick) begin
			div_cnt_q <= div_q;
		end else begin
			div_cnt_q <= div_cnt_q - 5'd1;
		end
	end

	// Minimum spacing between starts keeps the sample rate legal
	// Limitation: a start inside the window is dropped, not deferred
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			rate_cnt_q <= 10'd0;
		end else if (start_take) begin
			rate_cnt_q <= RATE_CYCLES - 10'd1;
		end else if (rate_cnt_q != 10'd0) begin
			rate_cnt_q <= rate_cnt_q - 10'd1;
		end
	end

	// Sequencer: idle, timed tracking, bit-by-bit approximation
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_q <= ST_IDLE;
			active_q <= 1'b0;
			trk_cnt_q <= 2'd0;
			bit_idx_q <= 4'd0;
			sar_dac_code_q <= 10'h000;
			result_q <= 10'h000;
		end else begin
			case (state_q)
			ST_IDLE: begin
				if (start_take) begin
					active_q <= 1'b1;
					trk_cnt_q <= 2'd0;
					bit_idx_q <= 4'd9;
					// First trial is the mid-scale bit
					sar_dac_code_q <= 10'h200;
					if (tm_q & (src_q != `SACS_SRC_EXT)) begin
						state_q <= ST_TRACK;
					end else begin
						state_q <= ST_CONV;
					end
				end
			end
			ST_TRACK: begin
				// Three SAR ticks of tracking, counted on the realigned divider
				if (sar_tick) begin
					trk_cnt_q <= trk_cnt_q + 2'd1;
					if (trk_cnt_q == `SACS_TRACK_SAR_CLOCKS - 2'd1) begin
						state_q <= ST_CONV;
					end
				end
			end
			ST_CONV: begin
				if (sar_tick) begin
					// Comparator high means the input is at or above the trial code
					if (bit_idx_q == 4'd0) begin
						result_q <= {sar_dac_code_q[9:1], cmp_s2_q};
						sar_dac_code_q <= 10'h000;
						active_q <= 1'b0;
						state_q <= ST_IDLE;
					end else begin
						sar_dac_code_q[bit_idx_q] <= cmp_s2_q;
						sar_dac_code_q[bit_idx_q - 4'd1] <= 1'b1;
						bit_idx_q <= bit_idx_q - 4'd1;
					end
				end
			end
			default: begin
				state_q <= ST_IDLE;
				active_q <= 1'b0;
			end
			endcase
		end
	end

	// Track switch; standby or a disabled converter always holds it open
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			sar_track_q <= 1'b0;
		end else if (~en_q | chip_standby) begin
			sar_track_q <= 1'b0;
		end else if (~tm_q) begin
			sar_track_q <= (state_q == ST_IDLE) & ~start_take;
		end else if (src_q == `SACS_SRC_EXT) begin
			sar_track_q <= (state_q == ST_IDLE) & ~trig_s2_q;
		end else begin
			sar_track_q <= (state_q == ST_TRACK);
		end
	end

endmodule // sacs_sequencer

`default_nettype wire

// file: tb/sacs_chk.sv
/* Port checker of sacs_sequencer.
 Assumes a bench that keeps conversions apart from interrupt clears. */
`default_nettype none
module sacs_chk (
	// Clock, reset, bus
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_waitrequest,
	// Analog side, interrupt
	input wire logic chip_standby,
	input wire logic sar_track_q,
	input wire logic [9:0] sar_dac_code_q,
	input wire logic [2:0] pga_gain_select_q,
	input wire logic irq_q
);
	// Write committed at this edge
	wire logic cw = avs_write && !avs_waitrequest && avs_byteenable[0];
	function automatic logic [9:0] low1(input logic [9:0] v);
		return v & (~v + 10'h001);
	endfunction
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	// One low cycle of waitrequest answers a request
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	// A trial step inside a conversion; steps into and out of the first trial and the final clear are left out
	sequence s_step;
		$changed(sar_dac_code_q) ##0 sar_dac_code_q != 10'h000 && sar_dac_code_q != 10'h200
			&& $past(sar_dac_code_q) != 10'h200;
	endsequence
	property p_ack;
		(avs_read || avs_write) && avs_waitrequest |=> s_ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer");
	property p_rst;
		disable iff (1'b0) sys_rst |=> avs_waitrequest && !irq_q && !sar_track_q;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_gain;
		cw && avs_address == 6'h04 |=> pga_gain_select_q == $past(avs_writedata[2:0]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain field");
	property p_step;
		s_step ##0 low1($past(sar_dac_code_q)) > 10'h001
			|-> low1(sar_dac_code_q) == low1($past(sar_dac_code_q)) >> 1;
	endproperty
	a_step: assert property (p_step) else $error("trial order");
	property p_hold;
		s_step |-> !sar_track_q;
	endproperty
	a_hold: assert property (p_hold) else $error("tracking in conversion");
	property p_stdby;
		chip_standby [*2] |-> !sar_track_q;
	endproperty
	a_stdby: assert property (p_stdby) else $error("tracking in standby");
	property p_stat;
		cw && avs_address == 6'h10 && avs_writedata[0] |=> ##1 !irq_q;
	endproperty
	a_stat: assert property (p_stat) else $error("irq after clear");
	property p_mask;
		cw && avs_address == 6'h14 && !avs_writedata[0] |=> ##1 !irq_q;
	endproperty
	a_mask: assert property (p_mask) else $error("irq after mask");
endmodule // sacs_chk
bind sacs_sequencer sacs_chk u_chk (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
	.avs_byteenable, .avs_waitrequest, .chip_standby, .sar_track_q, .sar_dac_code_q, .pga_gain_select_q, .irq_q);
`default_nettype wire

// file: tb/sacs_adc_model.sv
/* Comparator facing the trial code.
 Assumes the bench holds the input level steady per conversion. */
`default_nettype none
module sacs_adc_model (
	// Trial code and held input
	input wire logic [9:0] sar_dac_code_q,
	input wire logic [9:0] level,
	// Decision
	output logic sar_compare_in
);
	// Ideal decision; the sequencer adds its own synchroniser
	assign sar_compare_in = level >= sar_dac_code_q;
endmodule // sacs_adc_model
`default_nettype wire

// file: tb/tb_top.sv
/* Bench of sacs_sequencer: registers, four start sources, results, irq.
 Assumes the comparator model answers from the held level. */
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk, sys_rst, rd, wr, t2, t3, trig, stby, cmp, wq, trk, irq;
	logic [5:0] adr;
	logic [31:0] wd, rdat, d;
	logic [9:0] dac, lvl;
	logic [2:0] gain;
	logic [7:0] c;
	logic [1:0] src;
	int err_total = 0;
	int samples_checked = 0;
	sacs_sequencer dut (.sys_clk, .sys_rst, .avs_address(adr), .avs_read(rd), .avs_write(wr),
		.avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wq),
		.timer2_overflow(t2), .timer3_overflow(t3), .external_convert_trigger(trig), .chip_standby(stby),
		.sar_compare_in(cmp), .sar_track_q(trk), .sar_dac_code_q(dac), .pga_gain_select_q(gain), .irq_q(irq));
	sacs_adc_model adc (.sar_dac_code_q(dac), .level(lvl), .sar_compare_in(cmp));
	task automatic end_of_test();
		if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	// One bus cycle, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] v);
		adr <= a;
		wd <= {24'h00_0000, v};
		rd <= !w;
		wr <= w;
		@(posedge sys_clk);
		while (wq) @(posedge sys_clk);
		d = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge sys_clk);
	endtask
	function automatic logic [15:0] just(input logic [9:0] r, input logic lj);
		return lj ? {r, 6'h00} : {6'h00, r};
	endfunction
	// Clock at 100 MHz
	initial begin
		sys_clk = 0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Watchdog: the tests need about nine thousand cycles
	initial begin
		#200000;
		err_total++;
		end_of_test();
	end
	// Main sequence
	initial begin
		{sys_rst, rd, wr, t2, t3, trig, stby, adr, wd, lvl} = {7'h40, 6'h00, 32'h0000_0000, 10'h000};
		void'($urandom(32'hb1d2));
		repeat (4) @(posedge sys_clk);
		sys_rst <= 0;
		bus(0, 6'h04, 0);
		chk(d, 32'h0000_00f8);
		c = 8'h18 | 8'($urandom % 8);
		bus(1, 6'h04, c);
		bus(0, 6'h3c, 0);
		chk(d, 0);
		bus(0, 6'h04, 0);
		chk(d, c);
		chk(gain, c[2:0]);
		bus(1, 6'h14, 1);
		bus(1, 6'h00, 8'h80);
		stby <= 1;
		repeat (3) @(posedge sys_clk);
		chk(trk, 0);
		stby <= 0;
		// Every source code, both tracking modes, random justify
		for (int i = 0; i < 8; i++) begin
			src = i[1:0];
			c = {1'b1, i[2], 2'b00, src, 1'b0, 1'($urandom)};
			lvl <= i == 0 ? 10'h000 : i == 7 ? 10'h3ff : 10'($urandom);
			trig <= 0;
			bus(1, 6'h00, c);
			bus(1, 6'h10, 1);
			chk(trk, !c[6] || src == 2);
			{t2, t3, trig} <= {src == 3, src == 1, src == 2};
			if (src == 0) bus(1, 6'h00, c | 8'h10);
			@(posedge sys_clk);
			{t2, t3} <= 2'b00;
			repeat (4) @(posedge sys_clk);
			bus(0, 6'h00, 0);
			chk(d[4], 1);
			chk(trk, c[6] && src != 2);
			for (int n = 0; n < 40 && !d[5]; n++) bus(0, 6'h00, 0);
			chk(d[5:4], 2'b10);
			chk(irq, 1);
			// A timer pulse soon after a finished conversion falls inside the spacing window
			if (src[0]) begin
				{t2, t3} <= {src == 2'd3, src == 2'd1};
				@(posedge sys_clk);
				{t2, t3} <= 2'b00;
				bus(0, 6'h00, 0);
				chk(d[4], 0);
			end
			bus(0, 6'h08, 0);
			chk(d, just(lvl, c[0]) >> 8);
			bus(0, 6'h0c, 0);
			chk(d, just(lvl, c[0]) & 16'h00ff);
			bus(1, 6'h14, 0);
			@(posedge sys_clk);
			chk(irq, 0);
			bus(1, 6'h14, 1);
			@(posedge sys_clk);
			chk(irq, 1);
			bus(1, 6'h10, 1);
			@(posedge sys_clk);
			chk(irq, 0);
			repeat (1000) @(posedge sys_clk);
		end
		bus(1, 6'h14, 0);
		end_of_test();
	end
endmodule // tb_top
`default_nettype wire
